/* File: logic/ebps_dev.sv */
// Device end: external bus master and internal memory slave port
`default_nettype none
module ebps_dev
  import ebps_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  ebps_if.dev                     bus,
  input  wire logic [ID_W-1:0]    processor_identity,
  input  wire logic [BSIZE_W-1:0] bank_size_log2,
  input  wire logic               sync_mode,
  input  wire logic               is_master,
  input  wire logic               acc_req,
  input  wire logic               acc_write,
  input  wire ebps_width_e        acc_width,
  input  wire logic [ADDR_W-1:0]  acc_addr,
  input  wire logic [DATA_W-1:0]  acc_wdata,
  output logic                    acc_busy,
  output logic                    acc_done,
  output logic [DATA_W-1:0]       acc_rdata,
  input  wire logic               slv_stall,
  output logic                    slv_valid,
  output logic                    slv_write,
  output logic [3:0]              slv_strobes,
  output logic [ADDR_W-1:0]       slv_addr,
  output logic [DATA_W-1:0]       slv_wdata,
  input  wire logic [DATA_W-1:0]  slv_rdata
);
  typedef enum {EBPS_D_IDLE, EBPS_D_ACC, EBPS_D_END} ebps_dstate_e;
  ebps_dstate_e      st_reg, st_next;
  logic [ADDR_W-1:0] addr_reg, addr_next, hold_a_reg, hold_a_next;
  logic [DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [DATA_W-1:0] hold_d_reg, hold_d_next, sd_reg, sd_next;
  logic              wr_reg, wr_next, done_reg, done_next;
  ebps_width_e       wid_reg, wid_next;
  logic [BANKS-1:0]  bsel_reg, bsel_next;
  logic [3:0]        strb;
  logic [2:0]        susp_sync_reg;
  logic              susp_reg, susp_next, keep;
  logic              sv_reg, sv_next, sw_reg, sw_next;
  logic [3:0]        ss_reg, ss_next;
  logic [ADDR_W-1:0] sa_reg, sa_next;
  logic [ADDR_W-1:0] bank_idx;
  logic              drive, slv_acc, slv_rd, slv_out;
  logic              rdq_reg, rdq_next;
  logic [DATA_W-1:0] srd_reg, srd_next;

  // Suspend is a pin: three stages, change taken once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      susp_sync_reg <= 3'h7;
    end else begin
      susp_sync_reg <= {susp_sync_reg[1:0], bus.bus_suspend_n};
    end
  end
  always_comb begin
    susp_next = susp_reg;
    if (susp_sync_reg[1] == susp_sync_reg[2]) begin
      susp_next = !susp_sync_reg[2];
    end
  end

  assign keep = (processor_identity[ID_W-1:1] == ID_HOLD_PREFIX);
  // Strobes, address and write data drive as master only when unsuspended and in an access
  assign drive = is_master && !susp_reg && (st_reg != EBPS_D_IDLE);
  // Bank index; banks above the fourth get no select
  assign bank_idx = acc_addr >> bank_size_log2;

  always_comb begin
    strb = 4'hF;
    if (st_reg == EBPS_D_ACC) begin
      strb[0] = !(!wr_reg && wid_reg != EBPS_W_HIGH);
      strb[1] = !(!wr_reg && wid_reg != EBPS_W_LOW);
      strb[2] = !(wr_reg && wid_reg != EBPS_W_HIGH);
      strb[3] = !(wr_reg && wid_reg != EBPS_W_LOW);
    end
  end

  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    wid_next = wid_reg;
    bsel_next = bsel_reg;
    done_next = 1'b0;
    case (st_reg)
      EBPS_D_IDLE: begin
        // A request under suspend waits until suspend lifts
        if (acc_req && is_master && !susp_reg) begin
          st_next = EBPS_D_ACC;
          addr_next = acc_addr;
          wd_next = acc_wdata;
          wr_next = acc_write;
          wid_next = acc_width;
          bsel_next = BANK_IDLE;
          if (bank_idx < ADDR_W'(BANKS)) begin
            bsel_next[bank_idx[1:0]] = 1'b0;
          end
        end
      end
      EBPS_D_ACC: begin
        if (bus.ack && !susp_reg) begin
          st_next = EBPS_D_END;
          done_next = 1'b1;
          if (!wr_reg) begin
            rd_next = bus.ext_data_bus;
          end
          if (sync_mode) begin
            bsel_next = BANK_IDLE;
          end
        end
      end
      EBPS_D_END: begin
        st_next = EBPS_D_IDLE;
        if (!sync_mode) begin
          bsel_next = BANK_IDLE;
        end
      end
      default: st_next = EBPS_D_IDLE;
    endcase
  end

  // Slave side: far master's strobes address internal memory
  assign slv_acc = !is_master && (bus.strb_n != 4'hF);
  assign slv_rd = slv_acc && (bus.strb_n[1:0] != 2'h3);
  // Read data leaves from a register, so the far master is stalled until
  // internal memory has answered the registered address
  assign slv_out = slv_rd && rdq_reg;
  always_comb begin
    sv_next = slv_acc && !slv_stall;
    sw_next = (bus.strb_n[3:2] != 2'h3);
    ss_next = ~bus.strb_n;
    sa_next = bus.ext_addr_bus;
    sd_next = bus.ext_data_bus;
    hold_a_next = bus.ext_addr_bus;
    hold_d_next = bus.ext_data_bus;
    rdq_next = sv_reg && slv_rd;
    srd_next = sv_reg ? slv_rdata : srd_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= EBPS_D_IDLE;
      addr_reg <= ADDR_RST;
      wd_reg <= DATA_RST;
      rd_reg <= DATA_RST;
      wr_reg <= 1'b0;
      wid_reg <= EBPS_W_FULL;
      bsel_reg <= BANK_IDLE;
      done_reg <= 1'b0;
      susp_reg <= 1'b0;
      sv_reg <= 1'b0;
      sw_reg <= 1'b0;
      ss_reg <= 4'h0;
      sa_reg <= ADDR_RST;
      sd_reg <= DATA_RST;
      hold_a_reg <= ADDR_RST;
      hold_d_reg <= DATA_RST;
      rdq_reg <= 1'b0;
      srd_reg <= DATA_RST;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      wid_reg <= wid_next;
      bsel_reg <= bsel_next;
      done_reg <= done_next;
      susp_reg <= susp_next;
      sv_reg <= sv_next;
      sw_reg <= sw_next;
      ss_reg <= ss_next;
      sa_reg <= sa_next;
      sd_reg <= sd_next;
      hold_a_reg <= hold_a_next;
      hold_d_reg <= hold_d_next;
      rdq_reg <= rdq_next;
      srd_reg <= srd_next;
    end
  end

  // Keeper: with 00x identity, idle address and data lines are driven to their last level
  assign bus.dev_addr_o = drive ? addr_reg : hold_a_reg;
  assign bus.dev_addr_oe = drive || (keep && !bus.far_addr_oe);
  assign bus.dev_data_o = (drive && wr_reg) ? wd_reg :
                          (slv_out ? srd_reg : hold_d_reg);
  assign bus.dev_data_oe = (drive && wr_reg) || slv_out ||
                           (keep && !bus.far_data_oe);
  assign bus.bank_select_n = bsel_reg;
  assign bus.bank_oe = is_master && !susp_reg;
  assign bus.dev_strb_o = strb;
  assign bus.dev_strb_oe = drive;
  // Stall internal memory accesses by driving ack low
  assign bus.dev_ack_o = 1'b0;
  assign bus.dev_ack_oe = slv_acc && (slv_stall || (slv_rd && !rdq_reg));
  assign acc_busy = (st_reg != EBPS_D_IDLE) || susp_reg;
  assign acc_done = done_reg;
  assign acc_rdata = rd_reg;
  assign slv_valid = sv_reg;
  assign slv_write = sw_reg;
  assign slv_strobes = ss_reg;
  assign slv_addr = sa_reg;
  assign slv_wdata = sd_reg;
endmodule : ebps_dev
`default_nettype wire

/* File: logic/ebps_far.sv */
// Far end: host or other master, also external memory acknowledge
`default_nettype none
module ebps_far
  import ebps_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  ebps_if.far                    bus,
  input  wire logic              host_req,
  input  wire logic              host_write,
  input  wire ebps_width_e       host_width,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [DATA_W-1:0] host_wdata,
  output logic                   host_busy,
  output logic                   host_done,
  output logic [DATA_W-1:0]      host_rdata,
  input  wire logic              mem_wait,
  input  wire logic              suspend_req
);
  typedef enum {EBPS_F_IDLE, EBPS_F_ACC} ebps_fstate_e;
  ebps_fstate_e      st_reg, st_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
  logic              wr_reg, wr_next, done_reg, done_next;
  ebps_width_e       wid_reg, wid_next;
  logic [3:0]        strb;
  logic              is_lo, is_hi;

  assign is_lo = (wid_reg != EBPS_W_HIGH);
  assign is_hi = (wid_reg != EBPS_W_LOW);
  // Strobe order: {write_high, write_low, read_high, read_low}
  always_comb begin
    strb = 4'hF;
    if (st_reg == EBPS_F_ACC) begin
      strb[0] = !(!wr_reg && is_lo);
      strb[1] = !(!wr_reg && is_hi);
      strb[2] = !(wr_reg && is_lo);
      strb[3] = !(wr_reg && is_hi);
    end
  end

  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    wid_next = wid_reg;
    done_next = 1'b0;
    case (st_reg)
      EBPS_F_IDLE: begin
        if (host_req) begin
          st_next = EBPS_F_ACC;
          addr_next = host_addr;
          wd_next = host_wdata;
          wr_next = host_write;
          wid_next = host_width;
        end
      end
      EBPS_F_ACC: begin
        if (bus.ack) begin
          st_next = EBPS_F_IDLE;
          done_next = 1'b1;
          if (!wr_reg) begin
            rd_next = bus.ext_data_bus;
          end
        end
      end
      default: st_next = EBPS_F_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= EBPS_F_IDLE;
      addr_reg <= ADDR_RST;
      wd_reg <= DATA_RST;
      rd_reg <= DATA_RST;
      wr_reg <= 1'b0;
      wid_reg <= EBPS_W_FULL;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      wid_reg <= wid_next;
      done_reg <= done_next;
    end
  end

  // Only drives strobes while it holds the bus
  assign bus.far_strb_o = strb;
  assign bus.far_strb_oe = (st_reg == EBPS_F_ACC);
  assign bus.far_addr_o = addr_reg;
  assign bus.far_addr_oe = (st_reg == EBPS_F_ACC);
  assign bus.far_data_o = wd_reg;
  assign bus.far_data_oe = (st_reg == EBPS_F_ACC) && wr_reg;
  // Acts as slow external memory when the device is master
  assign bus.far_ack_o = 1'b0;
  assign bus.far_ack_oe = mem_wait && (st_reg == EBPS_F_IDLE);
  assign bus.bus_suspend_n = !suspend_req;
  assign host_busy = (st_reg != EBPS_F_IDLE);
  assign host_done = done_reg;
  assign host_rdata = rd_reg;
endmodule : ebps_far
`default_nettype wire

/* File: logic/ebps_if.sv */
// Pin bundle shared by the device end and the far end
`default_nettype none
interface ebps_if;
  import ebps_pkg::*;
  logic [ADDR_W-1:0] dev_addr_o, far_addr_o;
  logic              dev_addr_oe, far_addr_oe;
  logic [DATA_W-1:0] dev_data_o, far_data_o;
  logic              dev_data_oe, far_data_oe;
  logic [BANKS-1:0]  bank_select_n;
  logic              bank_oe;
  logic [3:0]        dev_strb_o, far_strb_o;
  logic              dev_strb_oe, far_strb_oe;
  logic              dev_ack_o, dev_ack_oe, far_ack_o, far_ack_oe;
  logic              bus_suspend_n;
  // Resolved wire levels; an undriven strobe or ack reads high (pull-up)
  logic [ADDR_W-1:0] ext_addr_bus;
  logic [DATA_W-1:0] ext_data_bus;
  logic [3:0]        strb_n;
  logic              ack;
  assign ext_addr_bus = dev_addr_oe ? dev_addr_o :
                        (far_addr_oe ? far_addr_o : '0);
  assign ext_data_bus = dev_data_oe ? dev_data_o :
                        (far_data_oe ? far_data_o : '0);
  assign strb_n = dev_strb_oe ? dev_strb_o :
                  (far_strb_oe ? far_strb_o : 4'hF);
  assign ack = dev_ack_oe ? dev_ack_o : (far_ack_oe ? far_ack_o : 1'b1);
  modport dev (output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe,
               bank_select_n, bank_oe, dev_strb_o, dev_strb_oe,
               dev_ack_o, dev_ack_oe,
               input ext_addr_bus, ext_data_bus, strb_n, ack,
               bus_suspend_n, far_addr_oe, far_data_oe);
  modport far (output far_addr_o, far_addr_oe, far_data_o, far_data_oe,
               far_strb_o, far_strb_oe, far_ack_o, far_ack_oe,
               bus_suspend_n,
               input ext_addr_bus, ext_data_bus, strb_n, ack,
               bank_select_n);
endinterface : ebps_if
`default_nettype wire

/* File: logic/ebps_pkg.sv */
// Shared constants and types for the external bus port ends
`default_nettype none
package ebps_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int WORD_W = 32;
  localparam int BANKS = 4;
  localparam int ID_W = 3;
  // Bank size field: log2 of words per bank, from the system config register
  localparam int BSIZE_W = 5;
  localparam logic [BSIZE_W-1:0] BSIZE_RST = 5'h14;
  // Identity prefix that enables the hold circuits (00x)
  localparam logic [1:0] ID_HOLD_PREFIX = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0000000000000000;
  localparam logic [BANKS-1:0] BANK_IDLE = 4'hF;
  // Access width codes
  typedef enum logic [1:0] {EBPS_W_LOW, EBPS_W_HIGH, EBPS_W_FULL} ebps_width_e;
endpackage : ebps_pkg
`default_nettype wire

/* File: test/ebps_checker.sv */
// Pin-level checks on the bundle that joins the two bus port ends
`default_nettype none
module ebps_checker
  import ebps_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             dev_addr_oe,
  input wire logic [3:0]       dev_strb_o,
  input wire logic             dev_strb_oe,
  input wire logic             far_strb_oe,
  input wire logic [3:0]       strb_n,
  input wire logic [BANKS-1:0] bank_select_n,
  input wire logic             bank_oe,
  input wire logic             ack,
  input wire logic             bus_suspend_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic dev_act;
  assign dev_act = dev_strb_oe && (dev_strb_o != 4'hF);
  property p_one_master; !(dev_strb_oe && far_strb_oe); endproperty
  a_one_master: assert property (p_one_master)
    else $error("both ends drive the strobes");
  property p_strb_addr; dev_act |-> dev_addr_oe; endproperty
  a_strb_addr: assert property (p_strb_addr)
    else $error("strobe without address");
  property p_sel_onehot; $onehot0(~bank_select_n); endproperty
  a_sel_onehot: assert property (p_sel_onehot)
    else $error("more than one bank selected");
  property p_sel_with_addr;
    $rose(bank_select_n != BANK_IDLE) |-> dev_addr_oe && dev_act;
  endproperty
  a_sel_with_addr: assert property (p_sel_with_addr)
    else $error("select not asserted with address");
  property p_sel_release;
    dev_act && ack && bank_select_n != BANK_IDLE
      |-> ##[1:2] bank_select_n == BANK_IDLE;
  endproperty
  a_sel_release: assert property (p_sel_release)
    else $error("select held after ack");
  property p_wait_stand; dev_act && !ack |=> $stable(dev_strb_o); endproperty
  a_wait_stand: assert property (p_wait_stand)
    else $error("strobes moved in a wait state");
  property p_susp_sel; !bus_suspend_n [*5] |-> !bank_oe; endproperty
  a_susp_sel: assert property (p_susp_sel)
    else $error("selects driven while suspended");
  property p_susp_strb; !bus_suspend_n [*5] |-> !dev_strb_oe; endproperty
  a_susp_strb: assert property (p_susp_strb)
    else $error("strobes driven while suspended");
  c_read: cover property (dev_act && !strb_n[0]);
  c_write: cover property (dev_act && !strb_n[2]);
  c_slave: cover property (far_strb_oe && strb_n != 4'hF);
  c_wait: cover property (dev_act && !ack);
endmodule : ebps_checker
`default_nettype wire

/* File: test/test_external_bus_port_strobes.sv */
// Bench joining the device end and the far end through one pin bundle
`default_nettype none
module test_external_bus_port_strobes;
  timeunit 1ns;
  timeprecision 1ps;
  import ebps_pkg::*;
  logic              core_clk, rst, sync_mode, is_master, acc_req, acc_write;
  logic              acc_busy, acc_done, slv_valid, slv_write, mem_wait;
  logic              host_req, host_write, host_busy, host_done, suspend_req;
  ebps_width_e       acc_width, host_width;
  logic [ADDR_W-1:0] acc_addr, host_addr, slv_addr;
  logic [DATA_W-1:0] acc_wdata, acc_rdata, host_wdata, host_rdata, slv_wdata;
  logic [3:0]        slv_strobes;
  logic [DATA_W-1:0] slv_rdata;
  logic [ID_W-1:0]   proc_id;
  int                fail_count, tests_run;
  ebps_if u_ebps_if ();
  ebps_dev u_ebps_dev (.core_clk, .rst, .bus(u_ebps_if.dev),
    .processor_identity(proc_id),
    .bank_size_log2(BSIZE_RST), .sync_mode,
    .is_master, .acc_req, .acc_write, .acc_width, .acc_addr, .acc_wdata,
    .acc_busy, .acc_done, .acc_rdata, .slv_stall(1'b0), .slv_valid,
    .slv_write, .slv_strobes, .slv_addr, .slv_wdata, .slv_rdata);
  // Internal memory stand-in: the word read is made from its address
  assign slv_rdata = {slv_addr, ~slv_addr};
  ebps_far u_ebps_far (.core_clk, .rst, .bus(u_ebps_if.far), .host_req,
    .host_write, .host_width, .host_addr, .host_wdata, .host_busy,
    .host_done, .host_rdata, .mem_wait, .suspend_req);
  ebps_checker u_ebps_checker (.core_clk, .rst,
    .dev_addr_oe(u_ebps_if.dev_addr_oe), .dev_strb_o(u_ebps_if.dev_strb_o),
    .dev_strb_oe(u_ebps_if.dev_strb_oe), .far_strb_oe(u_ebps_if.far_strb_oe),
    .strb_n(u_ebps_if.strb_n), .bank_select_n(u_ebps_if.bank_select_n),
    .bank_oe(u_ebps_if.bank_oe), .ack(u_ebps_if.ack),
    .bus_suspend_n(u_ebps_if.bus_suspend_n));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  // A bound that runs out ends the run at once
  task automatic give_up(input int n, input string msg);
    check(n < 20, msg);
    if (n >= 20) tally_and_finish();
  endtask : give_up
  task automatic dev_acc(input logic wr, input ebps_width_e w, input int idx,
                         input int waits);
    logic [1:0] m;
    logic [3:0] exp;
    int n;
    m = (w == EBPS_W_LOW) ? 2'h1 : ((w == EBPS_W_HIGH) ? 2'h2 : 2'h3);
    exp = wr ? ~{m, 2'h0} : ~{2'h0, m};
    acc_write = wr;
    acc_width = w;
    acc_addr = ADDR_W'(idx) << 20;
    acc_wdata = {~acc_addr, acc_addr};
    mem_wait = (waits > 0);
    acc_req = 1'b1;
    n = 0;
    while (u_ebps_if.dev_strb_oe !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    acc_req = 1'b0;
    give_up(n, "no strobes");
    check(u_ebps_if.strb_n === exp, "strobe pattern");
    check(u_ebps_if.ext_addr_bus === acc_addr, "address");
    check(u_ebps_if.bank_select_n === (idx < 4 ? ~(4'h1 << idx) : BANK_IDLE),
          "bank select");
    if (wr) check(u_ebps_if.ext_data_bus === acc_wdata, "write data");
    repeat (waits) @(negedge core_clk);
    check(acc_done !== 1'b1 && u_ebps_if.strb_n === exp, "wait");
    mem_wait = 1'b0;
    n = 0;
    while (acc_done !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    give_up(n, "no done");
    repeat (2) @(negedge core_clk);
  endtask : dev_acc
  task automatic suspend_hold();
    int n;
    suspend_req = 1'b1;
    repeat (4) @(negedge core_clk);
    acc_write = 1'b1;
    acc_width = EBPS_W_LOW;
    acc_req = 1'b1;
    repeat (8) begin
      @(negedge core_clk);
      check(u_ebps_if.dev_strb_oe !== 1'b1 && acc_done !== 1'b1 &&
            acc_busy === 1'b1, "susp");
    end
    suspend_req = 1'b0;
    n = 0;
    while (acc_done !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    acc_req = 1'b0;
    give_up(n, "no done after suspend");
    repeat (2) @(negedge core_clk);
  endtask : suspend_hold
  task automatic host_wr();
    int n;
    is_master = 1'b0;
    host_write = 1'b1;
    host_addr = 32'h00001234;
    host_wdata = 64'h0123456789ABCDEF;
    host_req = 1'b1;
    n = 0;
    while (slv_valid !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      check(u_ebps_if.dev_strb_oe !== 1'b1, "slave drove strobes");
      n++;
    end
    host_req = 1'b0;
    give_up(n, "no slave access");
    check(slv_write === 1'b1 && slv_addr === host_addr, "slave addr");
    check(slv_wdata === host_wdata, "slave data");
    check(slv_strobes === 4'hC, "slave write strobes");
    n = 0;
    while (host_busy === 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    give_up(n, "host stuck");
    is_master = 1'b1;
  endtask : host_wr
  task automatic host_rd();
    int n;
    @(negedge core_clk);
    is_master = 1'b0;
    host_write = 1'b0;
    host_addr = 32'h00005678;
    host_req = 1'b1;
    n = 0;
    while (host_done !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      if (host_busy === 1'b1) host_req = 1'b0;
      n++;
    end
    give_up(n, "no host read");
    check(n >= 3, "no slave stall");
    check(host_rdata === {host_addr, ~host_addr}, "host read");
    check(slv_strobes === 4'h3 && slv_write === 1'b0,
          "slave read strobes");
    is_master = 1'b1;
  endtask : host_rd
  initial begin
    rst = 1'b1;
    {sync_mode, acc_req, acc_write, host_req, host_write} = 5'h00;
    {mem_wait, suspend_req, fail_count, tests_run} = '0;
    is_master = 1'b1;
    proc_id = 3'h0;
    acc_width = EBPS_W_LOW;
    host_width = EBPS_W_FULL;
    {acc_addr, host_addr, acc_wdata, host_wdata} = '0;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++)
      dev_acc(i >= 3, ebps_width_e'(i % 3), i % 4, i % 2);
    check(u_ebps_if.ext_addr_bus === 32'h00100000, "keeper");
    sync_mode = 1'b1;
    dev_acc(1'b0, EBPS_W_FULL, 2, 3);
    check(acc_rdata === {~32'h00100000, 32'h00100000},
          "held read data");
    proc_id = 3'h2;
    @(negedge core_clk);
    check(u_ebps_if.dev_addr_oe === 1'b0 &&
          u_ebps_if.dev_data_oe === 1'b0, "no keeper");
    proc_id = 3'h1;
    dev_acc(1'b1, EBPS_W_LOW, 4, 0);
    suspend_hold();
    host_wr();
    host_rd();
    tally_and_finish();
  end
endmodule : test_external_bus_port_strobes
`default_nettype wire
